// ===== rtl/usb_device_link_control.sv
// Purpose: register and event logic of a full/low-speed USB device link.
// Assumes: event pulses from the serial engine are on core_clk.
// Notes: data-line pins are synchronised before use.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "usb_link_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_device_link_control #(
  parameter int unsigned IDLE_CYCLES = `IDLE_TIME_MS * 1000 * `CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usb_link_pkg::sie_evt_t sie_evt,
  input wire logic dp_pin,
  input wire logic dm_pin,
  output logic pin_change,
  output usb_link_pkg::link_ctl_t link_ctl,
  output logic [6:0] bus_address,
  output logic [79:0] ep_ctrl,
  output logic link_irq,
  output logic link_irq_high
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0] ctrl_q, cfg_q, stat_q, addr_q, evt_q, evten_q, err_q;
  logic [7:0] erren_q, pir_q, pie_q, ipr_q;
  logic [10:0] frame_q;
  logic [4:0] ep_q [16];
  logic [19:0] idle_cnt_q;
  logic [1:0] dp_sync_q, dm_sync_q;
  logic dp_last_q, dm_last_q;
  logic [7:0] rd_data;
  logic [5:0] idx;
  logic wr_go, acc, ep_hit, mapped;
  logic [7:0] wdat, evt_set, err_set;
  logic idle_hit;
  logic pu_dp_q, pu_dm_q, fs_q, resume_q, susp_q;

  // Link control levels, each held in its own flop.
  assign link_ctl = {pu_dp_q, pu_dm_q, fs_q, resume_q, susp_q};
  assign idx = paddr[7:2];
  assign acc = psel && penable && pready;
  assign wr_go = acc && pwrite && mapped;
  assign wdat = pwdata[7:0];
  assign ep_hit = (idx[5:4] == 2'h1);

  // ****************************************************************
  // APB read decode.
  // ****************************************************************
  always_comb begin
    mapped = 1'b1;
    rd_data = 8'h00;
    case (idx)
      `OFS_CTRL: rd_data = ctrl_q;
      `OFS_CFG: rd_data = cfg_q;
      `OFS_STAT: rd_data = stat_q;
      `OFS_ADDR: rd_data = addr_q;
      `OFS_FRML: rd_data = frame_q[7:0];
      `OFS_FRMH: rd_data = {5'h00, frame_q[10:8]};
      `OFS_EVT: rd_data = evt_q;
      `OFS_EVTEN: rd_data = evten_q;
      `OFS_ERR: rd_data = err_q;
      `OFS_ERREN: rd_data = erren_q;
      `OFS_PIR: rd_data = pir_q;
      `OFS_PIE: rd_data = pie_q;
      `OFS_IPR: rd_data = ipr_q;
      default: begin
        if (ep_hit) begin
          rd_data = {3'h0, ep_q[idx[3:0]]};
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready) ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Control, configuration and address.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 8'h00;
      cfg_q <= 8'h00;
      ipr_q <= 8'h00;
      pie_q <= 8'h00;
      evten_q <= 8'h00;
      erren_q <= 8'h00;
    end else if (ce && wr_go) begin
      if (idx == `OFS_CTRL) ctrl_q <= wdat & `CTRL_MASK;
      if (idx == `OFS_CFG) cfg_q <= wdat & `CFG_MASK;
      if (idx == `OFS_IPR) ipr_q <= wdat & `PIR_MASK;
      if (idx == `OFS_PIE) pie_q <= wdat & `PIR_MASK;
      if (idx == `OFS_EVTEN) evten_q <= wdat & `EVT_MASK;
      if (idx == `OFS_ERREN) erren_q <= wdat & `ERR_MASK;
    end
  end

  // Bus reset takes priority over a software write of the address.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 8'h00;
    end else if (ce) begin
      if (sie_evt.bus_reset) begin
        addr_q <= 8'h00;
      end else if (wr_go && idx == `OFS_ADDR) begin
        addr_q <= wdat & `ADDR_MASK;
      end
    end
  end

  // ****************************************************************
  // Endpoint control registers.
  // ****************************************************************
  generate
    for (genvar e = 0; e < 16; e++) begin : g_ep
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          ep_q[e] <= 5'h00;
        end else if (ce) begin
          if (sie_evt.bus_reset && e != 0) begin
            ep_q[e] <= 5'h00;
          end else if (wr_go && ep_hit && idx[3:0] == 4'(e)) begin
            ep_q[e] <= wdat[4:0] & 5'(`EP_MASK);
            if (e == 0) ep_q[e][`EP_CONDIS] <= 1'b0;
          end
        end
      end
      assign ep_ctrl[e*5 +: 5] = ep_q[e];
    end
  endgenerate

  // ****************************************************************
  // Frame number, transaction status and idle detection.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= 11'h000;
      stat_q <= 8'h00;
    end else if (ce) begin
      if (sie_evt.sof) frame_q <= sie_evt.frame;
      if (sie_evt.trn_done) stat_q <= sie_evt.trn_status & `STAT_MASK;
    end
  end

  assign idle_hit = (idle_cnt_q == 20'(IDLE_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_q <= 20'h0_0000;
      susp_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl_q[`CTRL_ENABLE] || sie_evt.sof || sie_evt.activity) begin
        idle_cnt_q <= 20'h0_0000;
        susp_q <= 1'b0;
      end else if (idle_hit) begin
        susp_q <= 1'b1;
      end else begin
        idle_cnt_q <= idle_cnt_q + 20'h0_0001;
      end
    end
  end

  // ****************************************************************
  // Event and error flags, write one to clear, set wins.
  // ****************************************************************
  assign err_set = sie_evt.errors & `ERR_MASK;
  assign evt_set = {1'b0, sie_evt.sof, sie_evt.stall_sent, idle_hit && !susp_q,
                    sie_evt.trn_done, sie_evt.activity, |(err_q & erren_q),
                    sie_evt.bus_reset};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_q <= 8'h00;
      err_q <= 8'h00;
      pir_q <= 8'h00;
    end else if (ce) begin
      evt_q <= ((wr_go && idx == `OFS_EVT) ? evt_q & ~wdat : evt_q) | evt_set;
      err_q <= ((wr_go && idx == `OFS_ERR) ? err_q & ~wdat : err_q) | err_set;
      pir_q <= ((wr_go && idx == `OFS_PIR) ? pir_q & ~wdat : pir_q)
               | {5'h00, |(evt_q & evten_q), 2'h0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_irq <= 1'b0;
      link_irq_high <= 1'b0;
    end else if (ce) begin
      link_irq <= pir_q[`PIR_SUMMARY] && pie_q[`PIR_SUMMARY];
      link_irq_high <= ipr_q[`PIR_SUMMARY];
    end
  end

  // ****************************************************************
  // Pins: pull-ups, resume and pin-change detection.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_dp_q <= 1'b0;
      pu_dm_q <= 1'b0;
      fs_q <= 1'b0;
      resume_q <= 1'b0;
      bus_address <= 7'h00;
    end else if (ce) begin
      pu_dp_q <= cfg_q[`CFG_PULLUP] && cfg_q[`CFG_FULLSPEED];
      pu_dm_q <= cfg_q[`CFG_PULLUP] && !cfg_q[`CFG_FULLSPEED];
      fs_q <= cfg_q[`CFG_FULLSPEED];
      resume_q <= ctrl_q[`CTRL_RESUME] && ctrl_q[`CTRL_ENABLE];
      bus_address <= addr_q[6:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dp_sync_q <= 2'b11;
      dm_sync_q <= 2'b11;
      dp_last_q <= 1'b1;
      dm_last_q <= 1'b1;
      pin_change <= 1'b0;
    end else if (ce) begin
      dp_sync_q <= {dp_sync_q[0], dp_pin};
      dm_sync_q <= {dm_sync_q[0], dm_pin};
      dp_last_q <= dp_sync_q[1];
      dm_last_q <= dm_sync_q[1];
      pin_change <= !ctrl_q[`CTRL_ENABLE]
                    && ((dp_last_q != dp_sync_q[1]) || (dm_last_q != dm_sync_q[1]));
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_enabled_long;
    ce && ctrl_q[`CTRL_ENABLE] ##1 ce && ctrl_q[`CTRL_ENABLE];
  endsequence
  sequence s_reset_seen;
    ce && sie_evt.bus_reset;
  endsequence
  sequence s_apb_access;
    ce && psel && penable && !pready;
  endsequence
  sequence s_ctl_write;
    ce && wr_go && idx == `OFS_CTRL;
  endsequence
  sequence s_addr_write;
    ce && wr_go && idx == `OFS_ADDR && !sie_evt.bus_reset;
  endsequence

  AST_IOC_OFF: assert property (s_enabled_long |-> !pin_change)
    else $error("pin change reported while module enabled");
  AST_IOC_ONLY: assert property ($rose(pin_change) |-> $past(!ctrl_q[`CTRL_ENABLE]))
    else $error("pin change without disabled module");
  AST_PULLUP: assert property (ce && cfg_q[`CFG_PULLUP] |=> !(link_ctl.pullup_dp && link_ctl.pullup_dm))
    else $error("both pull-ups on");
  AST_ADDR_RST: assert property (s_reset_seen |=> addr_q == 8'h00 ##1 (!ce || bus_address == 7'h00))
    else $error("address not cleared by bus reset");
  AST_FRAME: assert property (ce && sie_evt.sof |=> frame_q == $past(sie_evt.frame))
    else $error("frame number not loaded");
  AST_ERRFLAG: assert property (ce && |(err_q & erren_q) |=> evt_q[`EVT_ERR])
    else $error("error event flag not set");
  AST_EP0: assert property (ep_q[0][`EP_CONDIS] == 1'b0)
    else $error("endpoint 0 lost control transfers");
  AST_IDLE: assert property (ce && idle_hit && !susp_q && ctrl_q[`CTRL_ENABLE]
                             && !sie_evt.sof && !sie_evt.activity
                             |=> evt_q[`EVT_IDLE] && susp_q)
    else $error("idle not flagged after quiet period");
  AST_SUMMARY: assert property (ce && |(evt_q & evten_q) |=> pir_q[`PIR_SUMMARY])
    else $error("summary flag not raised");

  // ****************************************************************
  // Register bus assertions.
  // ****************************************************************
  AST_READY: assert property (s_apb_access |=> pready)
    else $error("ready not raised after access cycle");
  AST_READY_PULSE: assert property (ce && pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready cycle");
  AST_CTRL_WRITE: assert property (s_ctl_write |=> ctrl_q == ($past(wdat) & `CTRL_MASK))
    else $error("control write not taken");
  AST_ADDR_WRITE: assert property (s_addr_write |=> addr_q == ($past(wdat) & `ADDR_MASK))
    else $error("address write not taken");
  AST_ADDR_OUT: assert property (ce |=> bus_address == $past(addr_q[6:0]))
    else $error("bus address does not follow register");

  // ****************************************************************
  // Endpoint, frame and status assertions.
  // ****************************************************************
  AST_EP_RESET: assert property (s_reset_seen |=> ep_ctrl[79:5] == 75'h0)
    else $error("endpoints not cleared by bus reset");
  AST_EP0_KEEP: assert property (s_reset_seen && !(wr_go && ep_hit && idx[3:0] == 4'h0)
                                 |=> ep_q[0] == $past(ep_q[0]))
    else $error("endpoint 0 changed by bus reset");
  AST_EP_WRITE: assert property (ce && wr_go && ep_hit && idx[3:0] == 4'h3 && !sie_evt.bus_reset
                                 |=> ep_q[3] == $past(wdat[4:0]))
    else $error("endpoint control write not taken");
  AST_FRAME_HOLD: assert property (ce && !sie_evt.sof |=> frame_q == $past(frame_q))
    else $error("frame number changed without start of frame");
  AST_STAT: assert property (ce && sie_evt.trn_done
                             |=> stat_q == ($past(sie_evt.trn_status) & `STAT_MASK))
    else $error("transaction status not loaded");

  // ****************************************************************
  // Event, error and interrupt assertions.
  // ****************************************************************
  AST_SOF_FLAG: assert property (ce && sie_evt.sof |=> evt_q[`EVT_SOF])
    else $error("start of frame flag not set");
  AST_STALL_FLAG: assert property (ce && sie_evt.stall_sent |=> evt_q[`EVT_STALL])
    else $error("stall flag not set");
  AST_TRN_FLAG: assert property (ce && sie_evt.trn_done |=> evt_q[`EVT_TRN])
    else $error("transaction flag not set");
  AST_ACTV_FLAG: assert property (ce && sie_evt.activity |=> evt_q[`EVT_ACTV])
    else $error("activity flag not set");
  AST_RESET_FLAG: assert property (s_reset_seen |=> evt_q[`EVT_RST])
    else $error("bus reset flag not set");
  AST_EVT_W1C: assert property (ce && wr_go && idx == `OFS_EVT && evt_set == 8'h00
                                |=> (evt_q & $past(wdat)) == 8'h00)
    else $error("event flag not cleared by write");
  AST_ERR_SET: assert property (ce |=> (err_q & $past(err_set)) == $past(err_set))
    else $error("error flag not set");
  AST_ERR_W1C: assert property (ce && wr_go && idx == `OFS_ERR && err_set == 8'h00
                                |=> (err_q & $past(wdat)) == 8'h00)
    else $error("error flag not cleared by write");
  AST_IRQ: assert property (ce |=> link_irq == $past(pir_q[`PIR_SUMMARY] && pie_q[`PIR_SUMMARY]))
    else $error("summary request does not follow flag and enable");
  AST_IRQ_HIGH: assert property (ce |=> link_irq_high == $past(ipr_q[`PIR_SUMMARY]))
    else $error("priority output does not follow register");

  // ****************************************************************
  // Suspend, speed and pin assertions.
  // ****************************************************************
  AST_SUSP_CLEAR: assert property (ce && (sie_evt.sof || sie_evt.activity
                                   || !ctrl_q[`CTRL_ENABLE]) |=> !susp_q)
    else $error("suspend kept after traffic");
  AST_NO_EARLY_SUSP: assert property (ce && !susp_q && !idle_hit |=> !susp_q)
    else $error("suspend before quiet period ended");
  AST_IDLE_ONCE: assert property (susp_q |-> !evt_set[`EVT_IDLE])
    else $error("idle flag raised again while suspended");
  AST_FS_PULLUP: assert property (ce |=> pu_dp_q == $past(cfg_q[`CFG_PULLUP]
                                  && cfg_q[`CFG_FULLSPEED]))
    else $error("plus line pull-up wrong");
  AST_LS_PULLUP: assert property (ce |=> pu_dm_q == $past(cfg_q[`CFG_PULLUP]
                                  && !cfg_q[`CFG_FULLSPEED]))
    else $error("minus line pull-up wrong");
  AST_SPEED: assert property (ce |=> fs_q == $past(cfg_q[`CFG_FULLSPEED]))
    else $error("speed output does not follow configuration");
  AST_RESUME: assert property (ce && !ctrl_q[`CTRL_ENABLE] |=> !resume_q)
    else $error("resume driven while module disabled");
  AST_PIN_QUIET: assert property (ce && dp_sync_q[1] == dp_last_q && dm_sync_q[1] == dm_last_q
                                  |=> !pin_change)
    else $error("pin change without a line change");

endmodule : usb_device_link_control
`default_nettype wire

// ===== inc/usb_link_defs.svh
// Purpose: constants of the USB device link control block.
// Assumes: one 125 MHz core clock and APB register access.
// Notes: offsets are word indices; the byte address is four times the index.
`ifndef USB_LINK_DEFS_SVH
`define USB_LINK_DEFS_SVH
`define CLK_MHZ 125
`define IDLE_TIME_MS 3
`define OFS_CTRL 6'h00
`define OFS_CFG 6'h01
`define OFS_STAT 6'h02
`define OFS_ADDR 6'h03
`define OFS_FRML 6'h04
`define OFS_FRMH 6'h05
`define OFS_EVT 6'h06
`define OFS_EVTEN 6'h07
`define OFS_ERR 6'h08
`define OFS_ERREN 6'h09
`define OFS_PIR 6'h0A
`define OFS_PIE 6'h0B
`define OFS_IPR 6'h0C
`define OFS_EP_BASE 6'h10
`define CTRL_ENABLE 3
`define CTRL_RESUME 2
`define CFG_PULLUP 4
`define CFG_FULLSPEED 2
`define EVT_SOF 6
`define EVT_IDLE 4
`define EVT_ERR 1
`define EVT_STALL 5
`define EVT_TRN 3
`define EVT_ACTV 2
`define EVT_RST 0
`define STAT_MASK 8'h7E
`define PIR_SUMMARY 2
`define EP_CONDIS 3
`define CTRL_MASK 8'h7E
`define CFG_MASK 8'hDF
`define ADDR_MASK 8'h7F
`define EVT_MASK 8'h7F
`define ERR_MASK 8'h9F
`define EP_MASK 8'h1F
`define PIR_MASK 8'h04
`endif

// ===== inc/usb_link_pkg.sv
// Purpose: types of the USB device link control block.
// Assumes: nothing beyond the defines header.
// Notes: events arrive as one-cycle pulses from the serial engine.
package usb_link_pkg;
  typedef struct packed {
    logic sof;
    logic stall_sent;
    logic trn_done;
    logic activity;
    logic bus_reset;
    logic [7:0] errors;
    logic [10:0] frame;
    logic [7:0] trn_status;
  } sie_evt_t;
  typedef struct packed {
    logic pullup_dp;
    logic pullup_dm;
    logic full_speed;
    logic resume_drive;
    logic suspended;
  } link_ctl_t;
endpackage : usb_link_pkg

// ===== tb/usb_host_model.sv
// Purpose: far-side host model that feeds link events and data-line levels.
// Assumes: op and arg are driven just after a rising edge of core_clk.
// Notes: detached lines sit high through external pull-ups.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] op,
  input wire logic [10:0] arg,
  input wire logic attached,
  input wire logic pullup_dp,
  output usb_link_pkg::sie_evt_t sie_evt,
  output logic dp_pin,
  output logic dm_pin
);
  // Host pull-downs win over a line that no device pull-up holds.
  assign dp_pin = !attached || pullup_dp;
  assign dm_pin = !attached;
  // Ops 1 to 4 each become one event pulse; qualified fields are scrambled outside it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sie_evt <= '0;
    end else begin
      sie_evt <= '0;
      sie_evt.frame <= ~arg;
      sie_evt.trn_status <= ~arg[7:0];
      case (op)
        3'h1: begin
          sie_evt.sof <= 1'b1;
          sie_evt.frame <= arg;
        end
        3'h2: sie_evt.bus_reset <= 1'b1;
        3'h3: sie_evt.errors <= arg[7:0];
        3'h4: begin
          sie_evt.trn_done <= 1'b1;
          sie_evt.trn_status <= arg[7:0];
        end
        default: ;
      endcase
    end
  end
endmodule : usb_host_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the USB device link control block.
// Assumes: APB slave answers with pready; short idle count in simulation.
// Notes: expected values come from the register map and bit layout.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] op = 3'h0;
  logic [10:0] arg = 11'h000;
  logic attached = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, dp_pin, dm_pin, pin_change, link_irq, link_irq_high;
  logic [6:0] bus_address;
  logic [79:0] ep_ctrl;
  usb_link_pkg::sie_evt_t sie_evt;
  usb_link_pkg::link_ctl_t link_ctl;
  int failures = 0;
  int check_count = 0;
  int n;
  initial forever #4 core_clk = ~core_clk;
  usb_device_link_control #(.IDLE_CYCLES(50)) usb_device_link_control_inst (
    .core_clk(core_clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sie_evt(sie_evt), .dp_pin(dp_pin), .dm_pin(dm_pin),
    .pin_change(pin_change), .link_ctl(link_ctl), .bus_address(bus_address),
    .ep_ctrl(ep_ctrl), .link_irq(link_irq), .link_irq_high(link_irq_high));
  usb_host_model usb_host_model_inst (
    .core_clk(core_clk), .rst_b(rst_b), .op(op), .arg(arg), .attached(attached),
    .pullup_dp(link_ctl.pullup_dp), .sie_evt(sie_evt), .dp_pin(dp_pin), .dm_pin(dm_pin));
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string what);
    apb(1'b0, a, 32'h0);
    chk(what, {24'h0, e}, rd & {24'h0, m});
  endtask : rdc
  task automatic ev(input logic [2:0] o, input logic [10:0] a);
    @(posedge core_clk);
    op <= o;
    arg <= a;
    @(posedge core_clk);
    op <= 3'h0;
    repeat (4) @(posedge core_clk);
  endtask : ev
  task automatic pin_probe(input logic [31:0] exp);
    int seen = 0;
    @(posedge core_clk);
    attached <= ~attached;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      if (pin_change === 1'b1) seen++;
    end
    chk("pin_change", exp, seen);
  endtask : pin_probe
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    chk("bus_address", 32'h0, {25'h0, bus_address});
    rdc(8'h0C, 8'hFF, 8'h00, "device_bus_address");
    apb(1'b0, 8'h34, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    pin_probe(1);
    wr(8'h00, 8'h08);
    pin_probe(0);
    wr(8'h18, 8'h7F);
    repeat (10) @(posedge core_clk);
    rdc(8'h18, 8'h10, 8'h00, "idle_early");
    repeat (50) @(posedge core_clk);
    rdc(8'h18, 8'h10, 8'h10, "idle_flag");
    chk("suspended", 32'h1, {31'h0, link_ctl.suspended});
    ev(3'h1, 11'h5A3);
    chk("resumed", 32'h0, {31'h0, link_ctl.suspended});
    rdc(8'h10, 8'hFF, 8'hA3, "frame_low");
    rdc(8'h14, 8'hFF, 8'h05, "frame_high");
    rdc(8'h18, 8'h40, 8'h40, "sof_flag");
    wr(8'h1C, 8'h40);
    wr(8'h2C, 8'h04);
    wr(8'h30, 8'h04);
    repeat (3) @(posedge core_clk);
    rdc(8'h28, 8'h04, 8'h04, "summary_flag");
    chk("link_irq", 32'h1, {31'h0, link_irq});
    chk("link_irq_high", 32'h1, {31'h0, link_irq_high});
    wr(8'h2C, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("link_irq_off", 32'h0, {31'h0, link_irq});
    wr(8'h24, 8'h01);
    ev(3'h3, 11'h010);
    wr(8'h18, 8'h02);
    rdc(8'h20, 8'h9F, 8'h10, "error_flags");
    rdc(8'h18, 8'h02, 8'h00, "masked_error");
    ev(3'h3, 11'h081);
    rdc(8'h20, 8'h9F, 8'h91, "error_flags");
    rdc(8'h18, 8'h02, 8'h02, "error_event");
    ev(3'h4, 11'h0FF);
    rdc(8'h18, 8'h08, 8'h08, "trn_flag");
    rdc(8'h08, 8'hFF, 8'h7E, "transaction_status");
    for (n = 0; n < 16; n++) wr(8'h40 + 8'(4 * n), 8'(255 - n));
    for (n = 0; n < 16; n++) rdc(8'h40 + 8'(4 * n), 8'hFF, (n == 0) ? 8'h17 : 8'(31 - n),
                                 "endpoint_ctrl");
    chk("ep15_out", 32'h10, {27'h0, ep_ctrl[79:75]});
    wr(8'h0C, 8'hFF);
    rdc(8'h0C, 8'hFF, 8'h7F, "address_set");
    chk("bus_address", 32'h7F, {25'h0, bus_address});
    wr(8'h18, 8'h7F);
    ev(3'h2, 11'h000);
    rdc(8'h0C, 8'hFF, 8'h00, "address_reset");
    rdc(8'h18, 8'h01, 8'h01, "reset_flag");
    chk("ep5_reset", 32'h0, {27'h0, ep_ctrl[29:25]});
    chk("ep0_kept", 32'h17, {27'h0, ep_ctrl[4:0]});
    wr(8'h04, 8'h14);
    repeat (2) @(posedge core_clk);
    chk("full_speed_pullup", 32'h3, {30'h0, link_ctl.pullup_dp, link_ctl.full_speed});
    wr(8'h04, 8'h10);
    repeat (2) @(posedge core_clk);
    chk("low_speed_pullup", 32'h2, {30'h0, link_ctl.pullup_dm, link_ctl.pullup_dp});
    wr(8'h00, 8'h0C);
    repeat (2) @(posedge core_clk);
    chk("resume_drive", 32'h1, {31'h0, link_ctl.resume_drive});
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
